// File: verilog/lp_cfg.svh
`ifndef LP_CFG_SVH
`define LP_CFG_SVH
// Clock period in picoseconds (250 MHz)
`define CLK_PERIOD_PS 4000
// Round a least time in ns up to whole clock cycles
`define NS_TO_CYC(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Precharge period in ns
`define T_RP_NS 18
`define RP_CYC `NS_TO_CYC(`T_RP_NS)
// Per-bank and all-bank refresh cycle times in ns
`define T_RFCPB_NS 90
`define RFCPB_CYC `NS_TO_CYC(`T_RFCPB_NS)
`define T_RFCAB_NS 130
`define RFCAB_CYC `NS_TO_CYC(`T_RFCAB_NS)
// Mode register write and read busy times in clock cycles
`define MRW_CYC 10
`define MRR_CYC 4
// Final initialization interval in us
`define T_INIT_FINAL_US 10
`define INIT_FINAL_CYC `NS_TO_CYC(`T_INIT_FINAL_US * 1000)
// Burst of eight data beats on both edges
`define BURST_CYC 4
// Mode register address that carries the reset command
`define RESET_MR_ADDR 8'h3F
// Field positions on the captured command/address bits
`define CA_MA_LO_POS 4
`define CA_OP_LO_POS 2
// Reset value and timer width
`define MR_RESET_VAL 8'h00
`define TIMER_W 12
`endif

// File: verilog/lp_pkg.sv
package lp_pkg;
   // Device states
   typedef enum logic [4:0] {
      ST_POWER_ON, ST_RESETTING, ST_RESET_PD, ST_IDLE, ST_IDLE_PD, ST_SELF_REF,
      ST_DEEP_PD, ST_ROW_ACT, ST_ACT_PD, ST_READING, ST_WRITING, ST_PRECHARGING,
      ST_REF_PB, ST_REF_AB, ST_MRW, ST_MRR_IDLE, ST_MRR_ACT, ST_MRR_RST
   } state_t;
   // Decoded commands
   typedef enum logic [3:0] {
      CMD_NOP, CMD_MRW, CMD_MRR, CMD_REF_PB, CMD_REF_AB, CMD_SREF, CMD_ACT,
      CMD_WR, CMD_RD, CMD_PRE, CMD_DPD, CMD_BAD
   } cmd_t;
   // Pins from the memory controller
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic [9:0] ca_rise;
      logic [9:0] ca_fall;
   } pins_t;
   // Device status towards the pad logic
   typedef struct packed {
      state_t state;
      logic dq_oe_n;
      logic term_en;
      logic mrr_valid;
      logic [7:0] mrr_data;
      logic illegal;
      logic init_done;
   } dev_out_t;
   // All state of the controller
   typedef struct packed {
      dev_out_t out;
      logic cke_prev;
      pins_t pins_prev;
      logic wr_pend;
      logic rd_pend;
      logic [11:0] timer;
      logic [11:0] init_cnt;
      logic [255:0][7:0] mr;
   } ctrl_st_t;
endpackage : lp_pkg

// File: verilog/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 22,
   // Level each bit shows during reset, the idle level of its pin
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Raw pins
   input wire logic [W-1:0] i_pin,
   // Filtered level
   output logic [W-1:0] o_level
);
   // Three stages per bit
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // A change counts once stages two and three agree
   for (genvar b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge i_clk or posedge i_rst) begin
         if (i_rst) begin
            // Idle level, so no false edge follows reset
            s1_reg[b] <= RST_VAL[b];
            s2_reg[b] <= RST_VAL[b];
            s3_reg[b] <= RST_VAL[b];
            o_level[b] <= RST_VAL[b];
         end else begin
            s1_reg[b] <= i_pin[b];
            s2_reg[b] <= s1_reg[b];
            s3_reg[b] <= s2_reg[b];
            if (s2_reg[b] == s3_reg[b]) begin
               o_level[b] <= s3_reg[b];
            end
         end
      end
   end
endmodule : pin_sync

// File: verilog/cmd_decode.sv
`timescale 1ns/100ps
module cmd_decode (
   // Filtered pins and previous clock enable
   input wire lp_pkg::pins_t i_pins,
   input wire logic i_cke_prev,
   // Decoded command
   output lp_pkg::cmd_t o_cmd
);
   logic [3:0] op;
   assign op = i_pins.ca_rise[3:0];

   // Command from chip select, clock enable pair and CA0..CA3
   always_comb begin
      o_cmd = lp_pkg::CMD_BAD;
      if (i_pins.cs_n) begin
         o_cmd = lp_pkg::CMD_NOP;
      end else if (i_cke_prev && !i_pins.cke) begin
         // Entry commands on a falling clock enable
         if (op[2:0] == 3'h4) begin
            o_cmd = lp_pkg::CMD_SREF;
         end else if (op[2:0] == 3'h3) begin
            o_cmd = lp_pkg::CMD_DPD;
         end
      end else if (op[2:0] == 3'h7) begin
         o_cmd = lp_pkg::CMD_NOP;
      end else if (op[1:0] == 2'h2) begin
         o_cmd = lp_pkg::CMD_ACT;
      end else begin
         unique case (op)
            4'h0: o_cmd = lp_pkg::CMD_MRW;
            4'h8: o_cmd = lp_pkg::CMD_MRR;
            4'h4: o_cmd = lp_pkg::CMD_REF_PB;
            4'hC: o_cmd = lp_pkg::CMD_REF_AB;
            4'h1, 4'h9: o_cmd = lp_pkg::CMD_WR;
            4'h5, 4'hD: o_cmd = lp_pkg::CMD_RD;
            4'hB: o_cmd = lp_pkg::CMD_PRE;
            default: o_cmd = lp_pkg::CMD_BAD;
         endcase
      end
   end
endmodule : cmd_decode

// File: verilog/lp_state_ctrl.sv
// Summary of operation
// - Compare clock enable with previous edge level
// - Active bank, enable falls, deselected: active power down
// - Enable rises, deselected: active power down exits
// - Banks idle, enable falls, deselected: idle power down
// - Enable rises, deselected: idle power down exits
// - Resetting, enable falls: resetting power down
// - Resetting power down exits idle once init done
// - Self refresh entry by command, exit to idle
// - Self refresh: data hi-Z or terminated
// - Deep power down entry; exit to power-on
// - No-operation keeps state, operation continues
// - Activate from idle opens row
// - Refresh from idle enters refreshing state
// - Mode register write updates register
// - Mode register read returns value, matching state
// - Reset command starts automatic initialization
// - Precharge from idle or active enters precharging
// - Read or write from active starts burst
// - While reading: read restarts, write waits burst
// - While writing: write restarts, read waits burst
// - No-operation never cuts a running burst
`timescale 1ns/100ps
`include "lp_cfg.svh"
module lp_state_ctrl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Controller pins
   input wire lp_pkg::pins_t i_pins,
   // Termination enabled by configuration
   input wire logic i_term_enable,
   // Device status
   output lp_pkg::dev_out_t o_status
);
   // Timer loads
   localparam logic [11:0] RP_LD = 12'(`RP_CYC);
   localparam logic [11:0] RFCPB_LD = 12'(`RFCPB_CYC);
   localparam logic [11:0] RFCAB_LD = 12'(`RFCAB_CYC);
   localparam logic [11:0] MRW_LD = 12'(`MRW_CYC);
   localparam logic [11:0] MRR_LD = 12'(`MRR_CYC);
   localparam logic [11:0] BURST_LD = 12'(`BURST_CYC);
   localparam logic [11:0] INIT_LD = 12'(`INIT_FINAL_CYC);

   lp_pkg::ctrl_st_t st_reg; // Registered state
   lp_pkg::ctrl_st_t st_next; // Next state
   lp_pkg::pins_t pins_raw; // Filtered pins
   lp_pkg::pins_t pins; // Filtered pins, a held command shown once
   lp_pkg::cmd_t cmd; // Decoded command
   logic cke; // Clock enable at this edge
   logic cke_fall; // High then low
   logic cke_rise; // Low then high
   logic cke_high; // High at both edges
   logic cke_low; // Low at both edges
   logic done; // Timed operation ends this edge
   logic [7:0] ma; // Mode register address
   logic [7:0] opv; // Mode register operand

   // Pins cross into the clock domain
   pin_sync #(
      .W($bits(lp_pkg::pins_t)),
      .RST_VAL({1'b1, 1'b1, 20'h00000})
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_pins),
      .o_level(pins_raw)
   );

   // The filter shows every pin state for two edges or more; a command
   // counts only at its first edge, later edges read as a deselect.
   // Two identical commands back to back therefore merge into one.
   always_comb begin
      pins = pins_raw;
      if (pins_raw == st_reg.pins_prev) begin
         pins.cs_n = 1'b1;
      end
   end

   // Command decode
   cmd_decode u_dec (
      .i_pins(pins),
      .i_cke_prev(st_reg.cke_prev),
      .o_cmd(cmd)
   );

   // Clock enable edge classes
   assign cke = pins.cke;
   assign cke_fall = st_reg.cke_prev && !cke;
   assign cke_rise = !st_reg.cke_prev && cke;
   assign cke_high = st_reg.cke_prev && cke;
   assign cke_low = !st_reg.cke_prev && !cke;
   assign done = st_reg.timer <= 12'h001;
   assign ma = {pins.ca_fall[1:0], pins.ca_rise[`CA_MA_LO_POS +: 6]};
   assign opv = pins.ca_fall[`CA_OP_LO_POS +: 8];

   // Next state of the whole controller
   always_comb begin
      st_next = st_reg;
      st_next.cke_prev = cke;
      st_next.pins_prev = pins_raw;
      st_next.out.mrr_valid = 1'b0;
      // Timers run down
      if (st_reg.timer != 12'h000) begin
         st_next.timer = st_reg.timer - 12'h001;
      end
      if (st_reg.init_cnt != 12'h000) begin
         st_next.init_cnt = st_reg.init_cnt - 12'h001;
      end
      if (st_reg.init_cnt == 12'h001) begin
         st_next.out.init_done = 1'b1;
      end
      unique case (st_reg.out.state)
         // Power down family: hold while enable stays low
         lp_pkg::ST_ACT_PD, lp_pkg::ST_IDLE_PD, lp_pkg::ST_RESET_PD,
         lp_pkg::ST_SELF_REF, lp_pkg::ST_DEEP_PD: begin
            if (cke_rise && pins.cs_n) begin
               unique case (st_reg.out.state)
                  lp_pkg::ST_ACT_PD: st_next.out.state = lp_pkg::ST_ROW_ACT;
                  lp_pkg::ST_IDLE_PD: st_next.out.state = lp_pkg::ST_IDLE;
                  lp_pkg::ST_SELF_REF: st_next.out.state = lp_pkg::ST_IDLE;
                  lp_pkg::ST_DEEP_PD: st_next.out.state = lp_pkg::ST_POWER_ON;
                  default: begin
                     // Idle only once the final interval is over
                     st_next.out.state = st_reg.out.init_done ? lp_pkg::ST_IDLE
                                         : lp_pkg::ST_RESETTING;
                  end
               endcase
            end else if (!cke_low) begin
               st_next.out.illegal = 1'b1;
            end
         end
         // Row active
         lp_pkg::ST_ROW_ACT: begin
            if (cke_fall && pins.cs_n) begin
               st_next.out.state = lp_pkg::ST_ACT_PD;
            end else if (!cke_high) begin
               st_next.out.illegal = 1'b1;
            end else begin
               unique case (cmd)
                  lp_pkg::CMD_NOP: st_next.out.state = st_reg.out.state;
                  lp_pkg::CMD_RD: begin
                     st_next.out.state = lp_pkg::ST_READING;
                     st_next.timer = BURST_LD;
                  end
                  lp_pkg::CMD_WR: begin
                     st_next.out.state = lp_pkg::ST_WRITING;
                     st_next.timer = BURST_LD;
                  end
                  lp_pkg::CMD_MRR: begin
                     st_next.out.state = lp_pkg::ST_MRR_ACT;
                     st_next.timer = MRR_LD;
                     st_next.out.mrr_valid = 1'b1;
                     st_next.out.mrr_data = st_reg.mr[ma];
                  end
                  lp_pkg::CMD_PRE: begin
                     st_next.out.state = lp_pkg::ST_PRECHARGING;
                     st_next.timer = RP_LD;
                  end
                  default: st_next.out.illegal = 1'b1;
               endcase
            end
         end
         // All banks idle
         lp_pkg::ST_IDLE: begin
            if (cke_fall) begin
               if (pins.cs_n) begin
                  st_next.out.state = lp_pkg::ST_IDLE_PD;
               end else if (cmd == lp_pkg::CMD_SREF) begin
                  st_next.out.state = lp_pkg::ST_SELF_REF;
               end else if (cmd == lp_pkg::CMD_DPD) begin
                  st_next.out.state = lp_pkg::ST_DEEP_PD;
               end else begin
                  st_next.out.illegal = 1'b1;
               end
            end else if (!cke_high) begin
               st_next.out.illegal = 1'b1;
            end else begin
               unique case (cmd)
                  lp_pkg::CMD_NOP: st_next.out.state = st_reg.out.state;
                  lp_pkg::CMD_ACT: st_next.out.state = lp_pkg::ST_ROW_ACT;
                  lp_pkg::CMD_REF_PB: begin
                     st_next.out.state = lp_pkg::ST_REF_PB;
                     st_next.timer = RFCPB_LD;
                  end
                  lp_pkg::CMD_REF_AB: begin
                     st_next.out.state = lp_pkg::ST_REF_AB;
                     st_next.timer = RFCAB_LD;
                  end
                  lp_pkg::CMD_MRW: begin
                     if (ma == `RESET_MR_ADDR) begin
                        // Reset restarts automatic initialization
                        st_next.out.state = lp_pkg::ST_RESETTING;
                        st_next.init_cnt = INIT_LD;
                        st_next.out.init_done = 1'b0;
                     end else begin
                        st_next.out.state = lp_pkg::ST_MRW;
                        st_next.timer = MRW_LD;
                        st_next.mr[ma] = opv;
                     end
                  end
                  lp_pkg::CMD_MRR: begin
                     st_next.out.state = lp_pkg::ST_MRR_IDLE;
                     st_next.timer = MRR_LD;
                     st_next.out.mrr_valid = 1'b1;
                     st_next.out.mrr_data = st_reg.mr[ma];
                  end
                  lp_pkg::CMD_PRE: begin
                     st_next.out.state = lp_pkg::ST_PRECHARGING;
                     st_next.timer = RP_LD;
                  end
                  default: st_next.out.illegal = 1'b1;
               endcase
            end
         end
         // Power on and resetting accept reset; only resetting accepts reads
         lp_pkg::ST_POWER_ON, lp_pkg::ST_RESETTING: begin
            if (cke_fall && pins.cs_n
                && st_reg.out.state == lp_pkg::ST_RESETTING) begin
               st_next.out.state = lp_pkg::ST_RESET_PD;
            end else if (!cke_high) begin
               st_next.out.illegal = 1'b1;
            end else if (cmd == lp_pkg::CMD_MRW && ma == `RESET_MR_ADDR) begin
               st_next.out.state = lp_pkg::ST_RESETTING;
               st_next.init_cnt = INIT_LD;
               st_next.out.init_done = 1'b0;
            end else if (cmd == lp_pkg::CMD_MRR
                         && st_reg.out.state == lp_pkg::ST_RESETTING) begin
               st_next.out.state = lp_pkg::ST_MRR_RST;
               st_next.timer = MRR_LD;
               st_next.out.mrr_valid = 1'b1;
               st_next.out.mrr_data = st_reg.mr[ma];
            end else if (cmd != lp_pkg::CMD_NOP) begin
               st_next.out.illegal = 1'b1;
            end
         end
         // Bursts: same command restarts, the other waits for the end
         lp_pkg::ST_READING, lp_pkg::ST_WRITING: begin
            if (!cke_high) begin
               st_next.out.illegal = 1'b1;
            end else if ((cmd == lp_pkg::CMD_RD && st_reg.out.state == lp_pkg::ST_READING)
                      || (cmd == lp_pkg::CMD_WR && st_reg.out.state == lp_pkg::ST_WRITING)) begin
               st_next.timer = BURST_LD;
            end else if (cmd == lp_pkg::CMD_WR) begin
               st_next.wr_pend = 1'b1;
            end else if (cmd == lp_pkg::CMD_RD) begin
               st_next.rd_pend = 1'b1;
            end else if (cmd != lp_pkg::CMD_NOP) begin
               st_next.out.illegal = 1'b1;
            end
            // No-op never ends the burst early
            if (done && st_next.timer <= 12'h001) begin
               if (st_next.wr_pend) begin
                  st_next.out.state = lp_pkg::ST_WRITING;
                  st_next.timer = BURST_LD;
               end else if (st_next.rd_pend) begin
                  st_next.out.state = lp_pkg::ST_READING;
                  st_next.timer = BURST_LD;
               end else begin
                  st_next.out.state = lp_pkg::ST_ROW_ACT;
               end
               st_next.wr_pend = 1'b0;
               st_next.rd_pend = 1'b0;
            end
         end
         // Timed states accept only no-ops until they end
         default: begin
            if (!cke_high || cmd != lp_pkg::CMD_NOP) begin
               st_next.out.illegal = 1'b1;
            end
            if (done) begin
               unique case (st_reg.out.state)
                  lp_pkg::ST_MRR_ACT: st_next.out.state = lp_pkg::ST_ROW_ACT;
                  lp_pkg::ST_MRR_RST: st_next.out.state = lp_pkg::ST_RESETTING;
                  default: st_next.out.state = lp_pkg::ST_IDLE;
               endcase
            end
         end
      endcase
      // Data drivers on only while a read burst runs
      st_next.out.dq_oe_n = st_next.out.state != lp_pkg::ST_READING;
      // Self refresh: hi-Z or terminated to the output supply
      st_next.out.term_en = (st_next.out.state == lp_pkg::ST_SELF_REF)
                            && i_term_enable;
   end

   // State register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
         st_reg.out.state <= lp_pkg::ST_POWER_ON;
         st_reg.out.dq_oe_n <= 1'b1;
         st_reg.cke_prev <= 1'b1;
         st_reg.mr <= {256{`MR_RESET_VAL}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_status = st_reg.out;

   // Checks
   AST_CKE_PREV: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.cke_prev == $past(cke)) else $error("Previous enable not tracked");
   AST_APD_ENTER: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_ROW_ACT && cke_fall && pins.cs_n
      |=> st_reg.out.state == lp_pkg::ST_ACT_PD) else $error("No active power down");
   AST_APD_EXIT: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_ACT_PD && cke_rise && pins.cs_n
      |=> st_reg.out.state == lp_pkg::ST_ROW_ACT) else $error("Bad active exit");
   AST_IPD: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_IDLE && cke_fall && pins.cs_n
      ##1 cke_low [*2] |=> st_reg.out.state == lp_pkg::ST_IDLE_PD) else $error("Idle pd");
   AST_IPD_EXIT: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_IDLE_PD && cke_rise && pins.cs_n
      |=> st_reg.out.state == lp_pkg::ST_IDLE) else $error("Bad idle exit");
   AST_RPD_EXIT: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_RESET_PD && cke_rise && pins.cs_n
      |=> st_reg.out.state == ($past(st_reg.out.init_done) ? lp_pkg::ST_IDLE
          : lp_pkg::ST_RESETTING)) else $error("Bad resetting exit");
   AST_SR_TERM: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_SELF_REF |-> st_reg.out.dq_oe_n)
      else $error("Data driven in self refresh");
   AST_DPD_EXIT: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_DEEP_PD && cke_rise && pins.cs_n
      |=> st_reg.out.state == lp_pkg::ST_POWER_ON) else $error("Bad deep exit");
   AST_NOP_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state inside {lp_pkg::ST_IDLE, lp_pkg::ST_ROW_ACT}
      && cke_high && cmd == lp_pkg::CMD_NOP |=> $stable(st_reg.out.state))
      else $error("No-op moved state");
   AST_MRR: assert property (@(posedge i_clk) disable iff (i_rst)
      st_reg.out.state == lp_pkg::ST_IDLE && cke_high && cmd == lp_pkg::CMD_MRR
      |=> st_reg.out.mrr_valid && st_reg.out.state == lp_pkg::ST_MRR_IDLE)
      else $error("Mode read missing");
   AST_BURST_LEN: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(st_reg.out.state == lp_pkg::ST_READING)
      |-> (st_reg.out.state == lp_pkg::ST_READING) [*4]) else $error("Short burst");
   COV_APD: cover property (@(posedge i_clk) st_reg.out.state == lp_pkg::ST_ACT_PD);
   COV_SREF: cover property (@(posedge i_clk) st_reg.out.state == lp_pkg::ST_SELF_REF);
   COV_RD_WR: cover property (@(posedge i_clk)
      st_reg.out.state == lp_pkg::ST_READING ##1 st_reg.out.state == lp_pkg::ST_WRITING);
endmodule : lp_state_ctrl

// File: verif/mem_ctl_model.sv
`timescale 1ns/100ps
module mem_ctl_model (
   // Clock
   input wire logic i_clk,
   // Pins towards the device
   output lp_pkg::pins_t o_pins
);
   // Deselected and idle at time zero
   initial o_pins = '{cke: 1'b1, cs_n: 1'b1, ca_rise: 10'h000, ca_fall: 10'h000};
   // One pin state every two cycles, launched at the falling edge; only listed combinations
   task automatic drive(input logic ke, input logic cs, input logic [9:0] r, input logic [9:0] f);
      // Each state stands two edges so the device's filter passes it
      repeat (2) @(negedge i_clk);
      o_pins.cke = ke;
      o_pins.cs_n = cs;
      // A deselected CA bus floats, so it shows a toggling pattern
      o_pins.ca_rise = cs ? ~o_pins.ca_rise : r;
      o_pins.ca_fall = cs ? ~o_pins.ca_fall : f;
   endtask : drive
   // Deselect cycles, also the wait after any exit
   task automatic nops(input int n);
      repeat (n) drive(1'b1, 1'b1, 10'h000, 10'h000);
   endtask : nops
   // Mode register write
   task automatic mode_reg_write_cmd(input logic [7:0] ma, input logic [7:0] op);
      drive(1'b1, 1'b0, {ma[5:0], 4'h0}, {op, ma[7:6]});
   endtask : mode_reg_write_cmd
   // Reset command sent as a write to the reset address
   task automatic rst_cmd();
      mode_reg_write_cmd(8'h3F, 8'h00);
   endtask : rst_cmd
endmodule : mem_ctl_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   // Clock, reset and termination select
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_term_enable = 1'b0;
   // Pins and device status
   lp_pkg::pins_t pins;
   lp_pkg::dev_out_t st;
   // Counters
   int errors = 0;
   int compares = 0;
   // 250 MHz clock
   always #2 i_clk = ~i_clk;
   mem_ctl_model ctl (.i_clk(i_clk), .o_pins(pins));
   lp_state_ctrl dut (.i_clk(i_clk), .i_rst(i_rst), .i_pins(pins),
      .i_term_enable(i_term_enable), .o_status(st));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Wait a bounded time for a state, then compare
   task automatic wait_st(input lp_pkg::state_t s, input int lim);
      int n;
      n = 0;
      while (st.state !== s && n < lim) begin
         @(negedge i_clk);
         n++;
      end
      chk(st.state, s);
   endtask : wait_st
   // State must stand for n cycles
   task automatic hold(input lp_pkg::state_t s, input int n);
      repeat (n) begin
         @(negedge i_clk);
         chk(st.state, s);
      end
   endtask : hold
   // Power down entry, garbage while low, then exit
   task automatic pd_cycle(input lp_pkg::state_t pd, input lp_pkg::state_t back);
      ctl.drive(1'b0, 1'b1, 10'h000, 10'h000);
      ctl.drive(1'b0, 1'b0, 10'h3FF, 10'h3FF);
      wait_st(pd, 8);
      hold(pd, 4);
      ctl.nops(3);
      wait_st(back, 8);
   endtask : pd_cycle
   // Reset state and reset command
   task automatic t_reset();
      chk(st.state, lp_pkg::ST_POWER_ON);
      chk(st.dq_oe_n, 1'b1);
      ctl.nops(6);
      ctl.rst_cmd();
      ctl.nops(1);
      wait_st(lp_pkg::ST_RESETTING, 12);
      $display("test reset done");
   endtask : t_reset
   // Resetting power down before and after the init interval
   task automatic t_rpd();
      pd_cycle(lp_pkg::ST_RESET_PD, lp_pkg::ST_RESETTING);
      chk(st.init_done, 1'b0);
      ctl.drive(1'b1, 1'b0, 10'h058, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_MRR_RST, 8);
      wait_st(lp_pkg::ST_RESETTING, 12);
      repeat (2600) @(negedge i_clk);
      chk(st.init_done, 1'b1);
      pd_cycle(lp_pkg::ST_RESET_PD, lp_pkg::ST_IDLE);
      $display("test resetting power down done");
   endtask : t_rpd
   // Idle commands
   task automatic t_idle();
      hold(lp_pkg::ST_IDLE, 4);
      pd_cycle(lp_pkg::ST_IDLE_PD, lp_pkg::ST_IDLE);
      ctl.mode_reg_write_cmd(8'h05, 8'hA5);
      ctl.nops(1);
      wait_st(lp_pkg::ST_MRW, 8);
      wait_st(lp_pkg::ST_IDLE, 16);
      ctl.drive(1'b1, 1'b0, 10'h058, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_MRR_IDLE, 8);
      wait_st(lp_pkg::ST_IDLE, 12);
      chk(st.mrr_data, 8'hA5);
      ctl.mode_reg_write_cmd(8'hC5, 8'h5A);
      ctl.nops(1);
      wait_st(lp_pkg::ST_MRW, 8);
      wait_st(lp_pkg::ST_IDLE, 16);
      ctl.drive(1'b1, 1'b0, 10'h058, 10'h003);
      ctl.nops(1);
      wait_st(lp_pkg::ST_MRR_IDLE, 8);
      wait_st(lp_pkg::ST_IDLE, 12);
      chk(st.mrr_data, 8'h5A);
      ctl.drive(1'b1, 1'b0, 10'h004, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_REF_PB, 8);
      wait_st(lp_pkg::ST_IDLE, 40);
      ctl.drive(1'b1, 1'b0, 10'h00C, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_REF_AB, 8);
      wait_st(lp_pkg::ST_IDLE, 50);
      $display("test idle commands done");
   endtask : t_idle
   // Row, bursts and precharge
   task automatic t_bank();
      ctl.drive(1'b1, 1'b0, 10'h002, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_ROW_ACT, 8);
      pd_cycle(lp_pkg::ST_ACT_PD, lp_pkg::ST_ROW_ACT);
      ctl.drive(1'b1, 1'b0, 10'h058, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_MRR_ACT, 8);
      wait_st(lp_pkg::ST_ROW_ACT, 12);
      ctl.drive(1'b1, 1'b0, 10'h005, 10'h000);
      ctl.drive(1'b1, 1'b0, 10'h001, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_READING, 8);
      chk(st.dq_oe_n, 1'b0);
      wait_st(lp_pkg::ST_WRITING, 12);
      chk(st.dq_oe_n, 1'b1);
      ctl.drive(1'b1, 1'b0, 10'h005, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_READING, 12);
      hold(lp_pkg::ST_READING, 3);
      wait_st(lp_pkg::ST_ROW_ACT, 4);
      ctl.drive(1'b1, 1'b0, 10'h00B, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_PRECHARGING, 8);
      wait_st(lp_pkg::ST_IDLE, 12);
      ctl.drive(1'b1, 1'b0, 10'h00B, 10'h000);
      ctl.nops(1);
      wait_st(lp_pkg::ST_PRECHARGING, 8);
      wait_st(lp_pkg::ST_IDLE, 12);
      $display("test bank done");
   endtask : t_bank
   // Self refresh and deep power down
   task automatic t_low();
      ctl.drive(1'b0, 1'b0, 10'h004, 10'h000);
      ctl.drive(1'b0, 1'b1, 10'h000, 10'h000);
      wait_st(lp_pkg::ST_SELF_REF, 8);
      chk(st.term_en, 1'b0);
      chk(st.dq_oe_n, 1'b1);
      i_term_enable = 1'b1;
      repeat (2) @(negedge i_clk);
      chk(st.term_en, 1'b1);
      ctl.nops(4);
      wait_st(lp_pkg::ST_IDLE, 8);
      i_term_enable = 1'b0;
      ctl.drive(1'b0, 1'b0, 10'h003, 10'h000);
      ctl.drive(1'b0, 1'b1, 10'h000, 10'h000);
      wait_st(lp_pkg::ST_DEEP_PD, 8);
      ctl.nops(4);
      wait_st(lp_pkg::ST_POWER_ON, 8);
      ctl.rst_cmd();
      ctl.nops(1);
      wait_st(lp_pkg::ST_RESETTING, 12);
      chk(st.illegal, 1'b0);
      $display("test low power done");
   endtask : t_low
   // Verdict and end of run
   task automatic conclude();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      t_reset();
      t_rpd();
      t_idle();
      t_bank();
      t_low();
      conclude();
   end
   // Watchdog well beyond the expected run
   initial begin
      #40000;
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      conclude();
   end
endmodule : tb_top
